/* File: verilog/mcc_top.sv */
// Energy, CRC coverage and temperature request control registers.
`default_nettype none

module mcc_top #(
    parameter int LEN_W            = 13,
    parameter int SRC_COUNT        = 4,
    parameter int TEMP_CONV_CYCLES = mcc_pkg::TEMP_CONV_CYCLES
) (
    input  wire logic                     ref_clk,
    input  wire logic                     sys_rst,
    // Register port from the serial interface.
    input  wire logic                     reg_wr_en,
    input  wire logic                     reg_rd_en,
    input  wire logic [11:0]              reg_addr,
    input  wire logic [15:0]              reg_wdata,
    output logic      [15:0]              reg_rdata,
    // Energy accumulation inputs and outputs.
    input  wire logic                     run_bit,
    input  wire logic [LEN_W-1:0]         energy_period_length,
    input  wire logic [1:0]               crossing_source_field,
    input  wire logic [SRC_COUNT-1:0]     crossing_events,
    input  wire logic                     sample_tick_8k,
    output logic                          accumulator_active,
    output logic                          energy_interval_end,
    // CRC engine handshake.
    output logic                          crc_start,
    input  wire logic                     crc_calc_done,
    output logic                          crc_busy,
    output logic                          crc_done_set,
    output logic      [2:0]               crc_cover_waveform,
    output logic      [2:0]               crc_cover_cycle,
    output logic      [2:0]               crc_cover_noload,
    output logic      [3:0]               crc_cover_voltage,
    output logic      [2:0]               crc_cover_irq,
    // Temperature sensor handshake.
    output logic                          temp_conv_start,
    output logic      [1:0]               temp_average_select,
    output logic                          temp_ready_set
);

    localparam int TW = $clog2(TEMP_CONV_CYCLES + 1);

    // Refuse settings the logic cannot serve.
    if (LEN_W < 1 || LEN_W > 31 || SRC_COUNT < 1 || SRC_COUNT > 4 || TEMP_CONV_CYCLES < 1)
    begin : g_bad_param
        $error("mcc_top: parameter out of range");
    end

    logic        acc_enable_r;     // Accumulator enable bit.
    logic        acc_enable_nxt;
    logic        period_basis_r;   // Energy period basis bit.
    logic        period_basis_nxt;
    logic        crc_trig_r;       // Stored recompute bit, reads back.
    logic        crc_trig_nxt;
    logic        crc_busy_r;       // CRC calculation in flight.
    logic        crc_busy_nxt;
    logic        crc_start_r;      // One-cycle start to the CRC engine.
    logic        crc_start_nxt;
    logic        crc_done_r;       // One-cycle completion to status.
    logic        crc_done_nxt;
    logic [15:0] coverage_r;       // Per-register CRC coverage enables.
    logic [15:0] coverage_nxt;
    logic        temp_req_r;       // Temperature request, self-clearing.
    logic        temp_req_nxt;
    logic        temp_start_r;     // One-cycle start to the sensor.
    logic        temp_start_nxt;
    logic        temp_rdy_r;       // One-cycle ready to status.
    logic        temp_rdy_nxt;
    logic [1:0]  temp_avg_r;       // Averaging selection.
    logic [1:0]  temp_avg_nxt;
    logic [15:0] rdata_r;          // Registered read data.
    logic [15:0] rdata_nxt;

    logic        acc_run;          // Accumulation permitted.
    logic        crossing_sel;     // Crossing event of the chosen source.
    logic        period_tick;      // Event that advances the interval.
    logic        conv_done;        // Temperature timer expired.
    logic        wr_crc;           // Write to the recompute register.
    logic        wr_temp;          // Write to the temperature register.

    // Accumulation proceeds only while both enables are high.
    assign acc_run = acc_enable_r & run_bit;

    // Pick the crossing stream named by the source field; absent sources read low.
    assign crossing_sel = (32'(crossing_source_field) < SRC_COUNT)
                        ? crossing_events[crossing_source_field] : 1'b0;

    // The interval advances on crossings or on 8 kSPS samples.
    assign period_tick = period_basis_r ? sample_tick_8k : crossing_sel;

    // Interval counter, held clear while accumulation is stopped.
    mcc_interval_counter #(
        .W     (LEN_W)
    ) u_energy_period (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .clear   (~acc_run),
        .tick    (period_tick),
        .limit   (energy_period_length),
        .done    (energy_interval_end)
    );

    // Conversion timer, running only while a request is pending.
    mcc_interval_counter #(
        .W     (TW)
    ) u_temp_timer (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .clear   (~temp_req_r),
        .tick    (1'b1),
        .limit   (TW'(TEMP_CONV_CYCLES)),
        .done    (conv_done)
    );

    assign wr_crc  = reg_wr_en && (reg_addr == mcc_pkg::CRC_RECOMPUTE_OFS);
    assign wr_temp = reg_wr_en && (reg_addr == mcc_pkg::TEMP_SETUP_OFS);

    // Register writes and the side effects they start.
    always_comb
    begin
        acc_enable_nxt   = acc_enable_r;
        period_basis_nxt = period_basis_r;
        crc_trig_nxt     = crc_trig_r;
        coverage_nxt     = coverage_r;
        temp_avg_nxt     = temp_avg_r;
        crc_start_nxt    = 1'b0;
        crc_done_nxt     = 1'b0;
        crc_busy_nxt     = crc_busy_r;
        temp_start_nxt   = 1'b0;
        temp_rdy_nxt     = 1'b0;
        temp_req_nxt     = temp_req_r;

        // Energy setup bits.
        if (reg_wr_en && reg_addr == mcc_pkg::ENERGY_SETUP_OFS)
        begin
            acc_enable_nxt   = reg_wdata[mcc_pkg::ACC_ENABLE_BIT];
            period_basis_nxt = reg_wdata[mcc_pkg::PERIOD_BASIS_BIT];
        end

        // Coverage word, all sixteen bits writable.
        if (reg_wr_en && reg_addr == mcc_pkg::CRC_COVERAGE_OFS)
        begin
            coverage_nxt = reg_wdata;
        end

        // CRC completion clears busy and flags status.
        if (crc_busy_r && crc_calc_done)
        begin
            crc_busy_nxt = 1'b0;
            crc_done_nxt = 1'b1;
        end

        // A recompute write with the trigger bit set wins over a finishing calculation and restarts it.
        if (wr_crc)
        begin
            crc_trig_nxt = reg_wdata[mcc_pkg::CRC_TRIGGER_BIT];
            if (reg_wdata[mcc_pkg::CRC_TRIGGER_BIT])
            begin
                crc_start_nxt = 1'b1;
                crc_busy_nxt  = 1'b1;
                crc_done_nxt  = 1'b0;
            end
        end

        // Conversion end flags ready and clears the request.
        if (temp_req_r && conv_done)
        begin
            temp_req_nxt = 1'b0;
            temp_rdy_nxt = 1'b1;
        end

        // A new request wins over a clearing one and starts a fresh conversion.
        if (wr_temp)
        begin
            temp_avg_nxt = reg_wdata[mcc_pkg::TEMP_AVG_LSB +: mcc_pkg::TEMP_AVG_W];
            // A request in the finishing cycle starts the next conversion,
            // while the finished one still flags its ready pulse.
            if (reg_wdata[mcc_pkg::TEMP_REQUEST_BIT] && (!temp_req_r || conv_done))
            begin
                temp_req_nxt   = 1'b1;
                temp_start_nxt = 1'b1;
            end
        end
    end

    // Read multiplexer; unmapped addresses and reserved bits read zero.
    always_comb
    begin
        rdata_nxt = rdata_r;
        if (reg_rd_en)
        begin
            rdata_nxt = 16'h0000;
            case (reg_addr)
                mcc_pkg::ENERGY_SETUP_OFS:
                begin
                    rdata_nxt[mcc_pkg::ACC_ENABLE_BIT]   = acc_enable_r;
                    rdata_nxt[mcc_pkg::PERIOD_BASIS_BIT] = period_basis_r;
                end
                mcc_pkg::CRC_RECOMPUTE_OFS:
                begin
                    rdata_nxt[mcc_pkg::CRC_TRIGGER_BIT] = crc_trig_r;
                end
                mcc_pkg::CRC_COVERAGE_OFS:
                begin
                    rdata_nxt = coverage_r;
                end
                mcc_pkg::TEMP_SETUP_OFS:
                begin
                    rdata_nxt[mcc_pkg::TEMP_REQUEST_BIT] = temp_req_r;
                    rdata_nxt[mcc_pkg::TEMP_AVG_LSB +: mcc_pkg::TEMP_AVG_W] = temp_avg_r;
                end
                default:
                begin
                    rdata_nxt = 16'h0000;
                end
            endcase
        end
    end

    // All state registers; every field clears to zero.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            acc_enable_r   <= 1'b0;
            period_basis_r <= 1'b0;
            crc_trig_r     <= 1'b0;
            crc_busy_r     <= 1'b0;
            crc_start_r    <= 1'b0;
            crc_done_r     <= 1'b0;
            coverage_r     <= mcc_pkg::REG_RESET;
            temp_req_r     <= 1'b0;
            temp_start_r   <= 1'b0;
            temp_rdy_r     <= 1'b0;
            temp_avg_r     <= 2'h0;
            rdata_r        <= mcc_pkg::REG_RESET;
        end
        else
        begin
            acc_enable_r   <= acc_enable_nxt;
            period_basis_r <= period_basis_nxt;
            crc_trig_r     <= crc_trig_nxt;
            crc_busy_r     <= crc_busy_nxt;
            crc_start_r    <= crc_start_nxt;
            crc_done_r     <= crc_done_nxt;
            coverage_r     <= coverage_nxt;
            temp_req_r     <= temp_req_nxt;
            temp_start_r   <= temp_start_nxt;
            temp_rdy_r     <= temp_rdy_nxt;
            temp_avg_r     <= temp_avg_nxt;
            rdata_r        <= rdata_nxt;
        end
    end

    // Coverage groups handed to the CRC engine; a clear bit omits its register.
    assign crc_cover_waveform = coverage_r[mcc_pkg::COV_WAVE_LSB +: 3];
    assign crc_cover_cycle    = coverage_r[mcc_pkg::COV_CYCLE_LSB +: 3];
    assign crc_cover_noload   = coverage_r[mcc_pkg::COV_NOLOAD_LSB +: 3];
    assign crc_cover_voltage  = coverage_r[mcc_pkg::COV_VOLT_LSB +: 4];
    assign crc_cover_irq      = coverage_r[mcc_pkg::COV_IRQ_LSB +: 3];

    assign accumulator_active  = acc_run;
    assign crc_start           = crc_start_r;
    assign crc_busy            = crc_busy_r;
    assign crc_done_set        = crc_done_r;
    assign temp_conv_start     = temp_start_r;
    assign temp_average_select = temp_avg_r;
    assign temp_ready_set      = temp_rdy_r;
    assign reg_rdata           = rdata_r;

endmodule : mcc_top

`default_nettype wire

/* File: common/mcc_pkg.sv */
// Constants shared by the metering control register slice.
`default_nettype none

package mcc_pkg;

    // Register word offsets on the serial port.
    localparam logic [11:0] ENERGY_SETUP_OFS     = 12'h4B0;
    localparam logic [11:0] CRC_RECOMPUTE_OFS    = 12'h4B4;
    localparam logic [11:0] CRC_COVERAGE_OFS     = 12'h4B5;
    localparam logic [11:0] TEMP_SETUP_OFS       = 12'h4B6;

    // Field positions.
    localparam int ACC_ENABLE_BIT   = 0;
    localparam int PERIOD_BASIS_BIT = 1;
    localparam int CRC_TRIGGER_BIT  = 0;
    localparam int TEMP_REQUEST_BIT = 3;
    localparam int TEMP_AVG_LSB     = 0;
    localparam int TEMP_AVG_W       = 2;

    // Coverage bit groups.
    localparam int COV_WAVE_LSB     = 13;
    localparam int COV_CYCLE_LSB    = 10;
    localparam int COV_NOLOAD_LSB   = 7;
    localparam int COV_VOLT_LSB     = 3;
    localparam int COV_IRQ_LSB      = 0;

    // Reset values.
    localparam logic [15:0] REG_RESET = 16'h0000;

    // Temperature conversion time and its cycle count at 125 MHz.
    localparam int TEMP_CONV_TIME_NS = 1000000;
    localparam int CLK_PERIOD_NS     = 8;
    localparam int TEMP_CONV_CYCLES  = (TEMP_CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : mcc_pkg

`default_nettype wire

/* File: verilog/mcc_interval_counter.sv */
// Event counter that pulses once each time a programmed count of ticks elapses.
`default_nettype none

module mcc_interval_counter #(
    parameter int W = 16
) (
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    input  wire logic         clear,
    input  wire logic         tick,
    input  wire logic [W-1:0] limit,
    output logic              done
);

    // Refuse a width the counter cannot hold.
    if (W < 1 || W > 31)
    begin : g_bad_width
        $error("mcc_interval_counter: width out of range");
    end

    logic [W-1:0] count_r;   // Ticks seen in the current interval.
    logic [W-1:0] count_nxt; // Next tick count.
    logic         done_r;    // Registered end-of-interval pulse.
    logic         done_nxt;  // Next pulse value.
    logic [W-1:0] last;      // Count value that ends the interval.

    // A limit of zero is served as one so the interval never stalls.
    assign last = (limit == '0) ? W'(1) : limit;

    // Count ticks and wrap when the programmed figure is reached.
    always_comb
    begin
        count_nxt = count_r;
        done_nxt  = 1'b0;
        if (clear)
        begin
            // Clearing holds the counter at the start of an interval.
            count_nxt = '0;
        end
        else if (tick)
        begin
            if (count_r + W'(1) >= last)
            begin
                // Interval complete; start the next one from zero.
                count_nxt = '0;
                done_nxt  = 1'b1;
            end
            else
            begin
                count_nxt = count_r + W'(1);
            end
        end
    end

    // Register the counter and the pulse.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            count_r <= '0;
            done_r  <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            done_r  <= done_nxt;
        end
    end

    assign done = done_r;

endmodule : mcc_interval_counter

`default_nettype wire

/* File: dv/mcc_top_checker.sv */
// Port checker for the metering control register slice.
`default_nettype none

module mcc_top_checker #(
    parameter int TEMP_CONV_CYCLES = 20
) (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        reg_wr_en,
    input wire logic [11:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        run_bit,
    input wire logic        accumulator_active,
    input wire logic        energy_interval_end,
    input wire logic        crc_start,
    input wire logic        crc_calc_done,
    input wire logic        crc_busy,
    input wire logic        crc_done_set,
    input wire logic [2:0]  crc_cover_waveform,
    input wire logic [2:0]  crc_cover_cycle,
    input wire logic [2:0]  crc_cover_noload,
    input wire logic [3:0]  crc_cover_voltage,
    input wire logic [2:0]  crc_cover_irq,
    input wire logic        temp_conv_start,
    input wire logic        temp_ready_set
);
    timeunit 1ns;
    timeprecision 1ps;

    // Window in which the ready pulse must follow a sensor start.
    localparam int T_LO = TEMP_CONV_CYCLES - 2;
    localparam int T_HI = TEMP_CONV_CYCLES + 2;

    // Decoded write strobes for the coverage word, the recompute bit and the temperature request bit.
    wire logic wr_cov = reg_wr_en && (reg_addr == mcc_pkg::CRC_COVERAGE_OFS);
    wire logic wr_crc = reg_wr_en && (reg_addr == mcc_pkg::CRC_RECOMPUTE_OFS) && reg_wdata[0];
    wire logic wr_tmp = reg_wr_en && (reg_addr == mcc_pkg::TEMP_SETUP_OFS) && reg_wdata[3];

    // All checks share the one clock and its reset.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    cov_map_a: assert property (
        wr_cov |=> {crc_cover_waveform, crc_cover_cycle, crc_cover_noload,
                    crc_cover_voltage, crc_cover_irq} == $past(reg_wdata))
        else $error("coverage outputs differ from written word");
    crc_start_a: assert property (wr_crc |=> crc_start && crc_busy)
        else $error("recompute write did not start the engine");
    crc_done_a: assert property (
        crc_busy && crc_calc_done && !wr_crc |=> crc_done_set && !crc_busy)
        else $error("engine completion not flagged");
    done_cause_a: assert property (crc_done_set |-> $past(crc_busy && crc_calc_done))
        else $error("completion flag without engine completion");
    acc_gate_a: assert property (accumulator_active |-> run_bit)
        else $error("accumulator running without run bit");
    end_gate_a: assert property (energy_interval_end |-> $past(accumulator_active))
        else $error("interval end while accumulator stopped");
    temp_cause_a: assert property (temp_conv_start |-> $past(wr_tmp))
        else $error("sensor start without a request write");
    temp_early_a: assert property (temp_conv_start |=> !temp_ready_set [*8])
        else $error("temperature ready came too early");
    temp_ready_a: assert property (temp_conv_start |-> ##[T_LO:T_HI] temp_ready_set)
        else $error("temperature ready missing after conversion time");

    // Main scenarios that the bench must reach.
    crc_done_c: cover property (crc_done_set);
    temp_ready_c: cover property (temp_ready_set);
    interval_c: cover property (energy_interval_end);

endmodule : mcc_top_checker

bind mcc_top mcc_top_checker #(.TEMP_CONV_CYCLES(TEMP_CONV_CYCLES)) i_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .run_bit(run_bit), .accumulator_active(accumulator_active),
    .energy_interval_end(energy_interval_end), .crc_start(crc_start),
    .crc_calc_done(crc_calc_done), .crc_busy(crc_busy), .crc_done_set(crc_done_set),
    .crc_cover_waveform(crc_cover_waveform), .crc_cover_cycle(crc_cover_cycle),
    .crc_cover_noload(crc_cover_noload), .crc_cover_voltage(crc_cover_voltage),
    .crc_cover_irq(crc_cover_irq), .temp_conv_start(temp_conv_start),
    .temp_ready_set(temp_ready_set));

`default_nettype wire

/* File: dv/test_metering_config_crc_temp_controls.sv */
// Self-checking bench for the metering control register slice.
`default_nettype none

module test_metering_config_crc_temp_controls;
    timeunit 1ns;
    timeprecision 1ps;

    // Shortened conversion time so the run stays brief.
    localparam int TC = 20;

    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        reg_wr_en = 1'b0;
    logic        reg_rd_en = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [15:0] reg_wdata = 16'h0000;
    logic        run_bit = 1'b0;
    logic [1:0]  crossing_source_field = 2'h0;
    logic [3:0]  crossing_events = 4'h0;
    logic        sample_tick_8k = 1'b0;
    logic        crc_calc_done = 1'b0;
    logic [12:0] ep_len = 13'h0003;
    logic [15:0] reg_rdata;
    logic        acc_on, int_end, crc_start, crc_busy, done_set, conv_start, rdy_set;
    logic [2:0]  cv_wave, cv_cyc, cv_nl, cv_irq;
    logic [3:0]  cv_volt;
    logic [1:0]  avg_sel;
    int          n_fail = 0, tests_run = 0, cyc = 0, n_end = 0, n_done = 0, n_rdy = 0, t_rdy = 0;
    int          c0;

    // The clock toggles every half period of 8 ns.
    always #4 ref_clk = ~ref_clk;

    // Counts cycles and the one-cycle pulses the scenarios judge.
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (int_end === 1'b1) n_end <= n_end + 1;
        if (done_set === 1'b1) n_done <= n_done + 1;
        if (rdy_set === 1'b1)
        begin
            n_rdy <= n_rdy + 1;
            t_rdy <= cyc;
        end
    end

    mcc_top #(.LEN_W(13), .SRC_COUNT(4), .TEMP_CONV_CYCLES(TC)) i_dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .run_bit(run_bit),
        .energy_period_length(ep_len), .crossing_source_field(crossing_source_field),
        .crossing_events(crossing_events), .sample_tick_8k(sample_tick_8k),
        .accumulator_active(acc_on), .energy_interval_end(int_end), .crc_start(crc_start),
        .crc_calc_done(crc_calc_done), .crc_busy(crc_busy), .crc_done_set(done_set),
        .crc_cover_waveform(cv_wave), .crc_cover_cycle(cv_cyc), .crc_cover_noload(cv_nl),
        .crc_cover_voltage(cv_volt), .crc_cover_irq(cv_irq), .temp_conv_start(conv_start),
        .temp_average_select(avg_sel), .temp_ready_set(rdy_set));

    // Compares one value and reports a difference at once.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    // One register write, taken at the edge on which the task returns.
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr_en <= 1'b0;
    endtask : wr

    // One register read; the data is judged once the taking edge has landed.
    task automatic rd(input logic [11:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd_en <= 1'b0;
        #1;
        chk(reg_rdata, e, "read data");
    endtask : rd

    // Sends n single-cycle pulses on the tick and crossing inputs, then settles.
    task automatic pulse(input logic [4:0] m, input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            {sample_tick_8k, crossing_events} <= m;
            @(posedge ref_clk);
            {sample_tick_8k, crossing_events} <= 5'h00;
        end
        repeat (3) @(posedge ref_clk);
        #1;
    endtask : pulse

    // Reset values, an unmapped read and an idle CRC busy output.
    task automatic t_reset();
        rd(12'h4B0, 16'h0000);
        rd(12'h4B4, 16'h0000);
        rd(12'h4B5, 16'h0000);
        rd(12'h4B6, 16'h0000);
        rd(12'h4B7, 16'h0000);
        chk(crc_busy, 1'b0, "idle engine");
    endtask : t_reset

    // Walks a one through the coverage word, then all set and all clear.
    task automatic t_cov();
        logic [15:0] v;
        for (int i = 0; i < 18; i++)
        begin
            v = (i == 16) ? 16'hFFFF : (i == 17) ? 16'h0000 : 16'h0001 << i;
            wr(12'h4B5, v);
            #1;
            chk({cv_wave, cv_cyc, cv_nl, cv_volt, cv_irq}, v, "coverage");
            rd(12'h4B5, v);
        end
    endtask : t_cov

    // A stray completion, a zero write, then a full recompute.
    task automatic t_crc();
        @(posedge ref_clk);
        crc_calc_done <= 1'b1;
        @(posedge ref_clk);
        crc_calc_done <= 1'b0;
        wr(12'h4B4, 16'h0000);
        #1;
        chk(crc_start, 1'b0, "no start on zero");
        chk(n_done, 0, "stray completion");
        wr(12'h4B4, 16'hFFFF);
        #1;
        chk({crc_start, crc_busy}, 2'h3, "engine start");
        rd(12'h4B4, 16'h0001);
        @(posedge ref_clk);
        crc_calc_done <= 1'b1;
        @(posedge ref_clk);
        crc_calc_done <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk(n_done, 1, "completion flag");
        chk(crc_busy, 1'b0, "engine idle");
    endtask : t_crc

    // Sensor request with reserved bits, a repeat while pending, self-clear.
    task automatic t_temp();
        wr(12'h4B6, 16'hFFFB);
        c0 = cyc;
        #1;
        chk({conv_start, 13'h0000, avg_sel}, 16'h8003, "sensor start");
        rd(12'h4B6, 16'h000B);
        wr(12'h4B6, 16'h000B);
        #1;
        chk(conv_start, 1'b0, "repeat ignored");
        repeat (TC + 5) @(posedge ref_clk);
        #1;
        chk(n_rdy, 1, "ready pulse");
        chk(t_rdy - c0 >= TC && t_rdy - c0 <= TC + 2, 1'b1, "conversion time");
        rd(12'h4B6, 16'h0003);
    endtask : t_temp

    // Sample and crossing bases, wrong sources, and the run gate.
    task automatic t_energy();
        wr(12'h4B0, 16'h0003);
        run_bit <= 1'b1;
        pulse(5'h0F, 3);
        chk(n_end, 0, "crossings ignored");
        chk(acc_on, 1'b1, "accumulating");
        pulse(5'h10, 3);
        chk(n_end, 1, "sample interval");
        wr(12'h4B0, 16'h0001);
        crossing_source_field <= 2'h2;
        pulse(5'h02, 3);
        pulse(5'h10, 3);
        chk(n_end, 1, "other sources ignored");
        pulse(5'h04, 3);
        chk(n_end, 2, "crossing interval");
        ep_len <= 13'h0000;
        pulse(5'h04, 1);
        chk(n_end, 3, "zero length served as one");
        run_bit <= 1'b0;
        pulse(5'h04, 3);
        chk({acc_on, n_end[14:0]}, 16'h0003, "run bit clear");
        run_bit <= 1'b1;
        wr(12'h4B0, 16'h0000);
        pulse(5'h04, 3);
        chk({acc_on, n_end[14:0]}, 16'h0003, "enable clear");
    endtask : t_energy

    // Prints the counts and the verdict, then stops.
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    // Main sequence after the twelve-cycle reset.
    initial
    begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_cov();
        t_crc();
        t_temp();
        t_energy();
        test_done();
    end

    // Cuts a hang short well beyond the few hundred cycles the run needs.
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        n_fail++;
        test_done();
    end

endmodule : test_metering_config_crc_temp_controls

`default_nettype wire
